//--- shared/stir_cfg.svh
// Notes on behaviour
// [RULE1] Upper threshold is 16 bits: high byte at 8Ch, low byte at 8Dh.
// [RULE2] Flag register at 8Eh holds prox ready, ambient ready, low and high crossing.
// [RULE3] Low and high threshold crossings each set their own flag.
// [RULE4] A raised flag stays 1 until the host writes 1 to its bit.
// [RULE5] Interrupt pin is low while any flag is 1, released when all are 0.
// [RULE6] Modulator timing at 8Fh: delay, frequency, dead time, MSB to LSB.
// [RULE7] Modulation delay field sets emitter-to-evaluation delay, resets to 0.
// [RULE8] Dead time field sets edge suppression window, resets to 1.
// [RULE9] Host should program modulator timing with 1, equal to its reset value.
// [RULE10] Host does not use the ambient IR register at 90h.
// [RULE11] With no measurement requested the block sits in standby.
// [RULE12] In standby the emitter sink is off whatever current is programmed.
// [RULE13] Host sets the pointer by a write carrying only the register index.
// [RULE14] The following read returns the addressed register.
// [RULE15] Stop then start, or a repeated start, both work before the read.
// [RULE16] Pointer increments after each read byte.
// [RULE17] Lower threshold is 16 bits: high byte at 8Ah, low byte at 8Bh.
// [RULE18] Source select 0 applies thresholds to proximity, 1 to ambient.
// [RULE19] Count code n needs 2**n consecutive results beyond a threshold.
// [RULE20] Separate enables gate crossing, prox ready and ambient ready flags.
// [RULE21] High flag when result above upper, low flag when below lower.
// [RULE22] Ready flag set when a new result arrives and its enable is 1.
// [RULE23] Frequency field is two bits selecting one of four frequencies.
`ifndef STIR_CFG_SVH
`define STIR_CFG_SVH

`define STIR_I2C_ADDR 7'h2a
`define STIR_OFF_ICTL 8'h89
`define STIR_OFF_LO_H 8'h8a
`define STIR_OFF_LO_L 8'h8b
`define STIR_OFF_HI_H 8'h8c
`define STIR_OFF_HI_L 8'h8d
`define STIR_OFF_FLAGS 8'h8e
`define STIR_OFF_MTIM 8'h8f
`define STIR_OFF_AIR 8'h90
`define STIR_MTIM_RESET 8'h01
`define STIR_FLAG_PROX 3
`define STIR_FLAG_ALS 2
`define STIR_FLAG_LOW 1
`define STIR_FLAG_HIGH 0
`define STIR_ICTL_CNT_HI 7
`define STIR_ICTL_CNT_LO 5
`define STIR_ICTL_PROX_EN 3
`define STIR_ICTL_ALS_EN 2
`define STIR_ICTL_LIM_EN 1
`define STIR_ICTL_SEL 0
`define STIR_MTIM_DLY_HI 7
`define STIR_MTIM_DLY_LO 5
`define STIR_MTIM_FRQ_HI 4
`define STIR_MTIM_FRQ_LO 3
`define STIR_MTIM_DT_HI 2
`define STIR_MTIM_DT_LO 0

`endif

//--- shared/stir_pkg.sv
package stir_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_AACK,
        ST_WBYTE,
        ST_WACK,
        ST_RBYTE,
        ST_RACK
    } stir_i2c_state_e;

    typedef struct packed {
        logic wr_stb;
        logic wr_first;
        logic [7:0] wr_data;
        logic rd_take;
    } stir_bus_s;

    typedef struct packed {
        logic [15:0] value;
        logic valid;
    } stir_result_s;

endpackage

//--- rtl/stir_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "stir_cfg.svh"

module stir_i2c_slave #(
    parameter logic [6:0] DEV_ADDR = `STIR_I2C_ADDR
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_out,
    // Register side
    input wire logic [7:0] rd_data_in,
    output stir_pkg::stir_bus_s bus_out
);
    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;
    logic rise, fall, start, stop;
    stir_pkg::stir_i2c_state_e st_q;
    logic [7:0] sh_q;
    logic [3:0] cnt_q;
    logic first_q, nack_q, sda_oe_q;
    stir_pkg::stir_bus_s bus_q;

    // Pins are asynchronous to clk_in
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
            {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
        end else begin
            {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_in, scl_s1_q, scl_s2_q};
            {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_in, sda_s1_q, sda_s2_q};
        end
    end

    assign rise = scl_s2_q & ~scl_s3_q;
    assign fall = ~scl_s2_q & scl_s3_q;
    assign start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    assign stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_q <= stir_pkg::ST_IDLE;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            first_q <= 1'b0;
            nack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            bus_q <= '0;
        end else begin
            bus_q.wr_stb <= 1'b0;
            bus_q.rd_take <= 1'b0;
            // [RULE15] Repeated start honoured
            if (start) begin
                st_q <= stir_pkg::ST_ADDR;
                cnt_q <= 4'h0;
                sda_oe_q <= 1'b0;
            end else if (stop) begin
                st_q <= stir_pkg::ST_IDLE;
                sda_oe_q <= 1'b0;
            end else if (rise) begin
                if (st_q == stir_pkg::ST_ADDR || st_q == stir_pkg::ST_WBYTE) begin
                    sh_q <= {sh_q[6:0], sda_s2_q};
                    cnt_q <= cnt_q + 4'h1;
                end
                if (st_q == stir_pkg::ST_RACK) begin
                    nack_q <= sda_s2_q;
                end
            end else if (fall) begin
                unique case (st_q)
                    stir_pkg::ST_IDLE: ;
                    stir_pkg::ST_ADDR: if (cnt_q == 4'h8) begin
                        if (sh_q[7:1] == DEV_ADDR) begin
                            st_q <= stir_pkg::ST_AACK;
                            sda_oe_q <= 1'b1;
                        end else begin
                            st_q <= stir_pkg::ST_IDLE;
                        end
                    end
                    stir_pkg::ST_AACK: begin
                        cnt_q <= 4'h0;
                        first_q <= 1'b1;
                        // [RULE14] Addressed byte goes out
                        if (sh_q[0]) begin
                            st_q <= stir_pkg::ST_RBYTE;
                            sh_q <= rd_data_in;
                            sda_oe_q <= ~rd_data_in[7];
                            bus_q.rd_take <= 1'b1;
                        end else begin
                            st_q <= stir_pkg::ST_WBYTE;
                            sda_oe_q <= 1'b0;
                        end
                    end
                    stir_pkg::ST_WBYTE: if (cnt_q == 4'h8) begin
                        st_q <= stir_pkg::ST_WACK;
                        sda_oe_q <= 1'b1;
                        bus_q.wr_stb <= 1'b1;
                        bus_q.wr_first <= first_q;
                        bus_q.wr_data <= sh_q;
                        first_q <= 1'b0;
                    end
                    stir_pkg::ST_WACK: begin
                        st_q <= stir_pkg::ST_WBYTE;
                        cnt_q <= 4'h0;
                        sda_oe_q <= 1'b0;
                    end
                    stir_pkg::ST_RBYTE: if (cnt_q == 4'h7) begin
                        st_q <= stir_pkg::ST_RACK;
                        sda_oe_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                        sh_q <= {sh_q[6:0], 1'b0};
                        sda_oe_q <= ~sh_q[6];
                    end
                    stir_pkg::ST_RACK: if (nack_q) begin
                        st_q <= stir_pkg::ST_IDLE;
                    end else begin
                        // Host acked, next register follows
                        st_q <= stir_pkg::ST_RBYTE;
                        cnt_q <= 4'h0;
                        sh_q <= rd_data_in;
                        sda_oe_q <= ~rd_data_in[7];
                        bus_q.rd_take <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign sda_oe_out = sda_oe_q;
    assign bus_out = bus_q;

    // [RULE14] Ack only for own address
    addr_ack_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (fall && st_q == stir_pkg::ST_ADDR && cnt_q == 4'h8 && sh_q[7:1] != DEV_ADDR)
        |=> !sda_oe_q) else $error("foreign address acknowledged");

endmodule
`default_nettype wire

//--- rtl/stir_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "stir_cfg.svh"

module stir_top (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Measurement results
    input wire stir_pkg::stir_result_s prox_in,
    input wire stir_pkg::stir_result_s als_in,
    // Measurement demand and emitter
    input wire logic prox_request_in,
    input wire logic als_request_in,
    input wire logic [7:0] led_current_in,
    output logic [7:0] led_sink_out,
    output logic standby_out,
    // Modulator timing fields
    output logic [2:0] mod_delay_out,
    output logic [1:0] prox_freq_out,
    output logic [2:0] dead_time_out,
    // Interrupt pin
    output logic int_n_out
);
    stir_pkg::stir_bus_s bus;
    logic sda_oe;
    logic [7:0] ptr_q;
    logic [7:0] rd_data_q;
    logic [15:0] thr_lo_q, thr_hi_q;
    logic [7:0] ictl_q, mtim_q;
    logic [3:0] flags_q, flags_d, flag_set, flag_clr;
    logic [7:0] above_cnt_q, below_cnt_q, need;
    logic [15:0] sel_val;
    logic sel_valid, wr_reg, above, below;
    logic above_hit, below_hit;
    logic int_n_q, standby_q;
    logic [7:0] led_sink_q;

    stir_i2c_slave stir_i2c_slave_inst (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_oe_out(sda_oe),
        .rd_data_in(rd_data_q),
        .bus_out(bus)
    );

    function automatic logic [7:0] read_mux(input logic [7:0] addr);
        logic [7:0] v;
        v = 8'h00;
        unique case (addr)
            `STIR_OFF_ICTL: v = ictl_q;
            `STIR_OFF_LO_H: v = thr_lo_q[15:8];
            `STIR_OFF_LO_L: v = thr_lo_q[7:0];
            `STIR_OFF_HI_H: v = thr_hi_q[15:8];
            `STIR_OFF_HI_L: v = thr_hi_q[7:0];
            `STIR_OFF_FLAGS: v = {4'h0, flags_q};
            `STIR_OFF_MTIM: v = mtim_q;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Pin only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe_out = sda_oe;

    // First data byte sets the pointer, later ones hit registers
    assign wr_reg = bus.wr_stb & ~bus.wr_first;

    // [RULE13] Index-only write loads pointer
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ptr_q <= 8'h00;
        end else if (bus.wr_stb && bus.wr_first) begin
            ptr_q <= bus.wr_data;
        // [RULE16] Pointer steps per byte
        end else if (bus.rd_take || wr_reg) begin
            ptr_q <= ptr_q + 8'h01;
        end
    end

    // [RULE14] Data follows the pointer
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= read_mux(ptr_q);
        end
    end

    // [RULE1] Upper threshold bytes
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            thr_hi_q <= 16'h0000;
        end else if (wr_reg && ptr_q == `STIR_OFF_HI_H) begin
            thr_hi_q[15:8] <= bus.wr_data;
        end else if (wr_reg && ptr_q == `STIR_OFF_HI_L) begin
            thr_hi_q[7:0] <= bus.wr_data;
        end
    end

    // [RULE17] Lower threshold bytes
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            thr_lo_q <= 16'h0000;
        end else if (wr_reg && ptr_q == `STIR_OFF_LO_H) begin
            thr_lo_q[15:8] <= bus.wr_data;
        end else if (wr_reg && ptr_q == `STIR_OFF_LO_L) begin
            thr_lo_q[7:0] <= bus.wr_data;
        end
    end

    // [RULE20] Control with enables
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ictl_q <= 8'h00;
        end else if (wr_reg && ptr_q == `STIR_OFF_ICTL) begin
            ictl_q <= bus.wr_data & 8'hef;
        end
    end

    // [RULE6] Timing register, reset 01h
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mtim_q <= `STIR_MTIM_RESET;
        end else if (wr_reg && ptr_q == `STIR_OFF_MTIM) begin
            mtim_q <= bus.wr_data;
        end
    end

    // [RULE18] Source select
    assign sel_val = ictl_q[`STIR_ICTL_SEL] ? als_in.value : prox_in.value;
    assign sel_valid = ictl_q[`STIR_ICTL_SEL] ? als_in.valid : prox_in.valid;
    // [RULE21] Strict compares
    assign above = sel_val > thr_hi_q;
    assign below = sel_val < thr_lo_q;
    // [RULE19] Count code to run length
    assign need = 8'h01 << ictl_q[`STIR_ICTL_CNT_HI:`STIR_ICTL_CNT_LO];
    // At-or-past compare so a run left from a longer code still fires
    assign above_hit = sel_valid & above & (above_cnt_q + 8'h01 >= need);
    assign below_hit = sel_valid & below & (below_cnt_q + 8'h01 >= need);

    // Run restarts after a raise so a long excursion fires once per run
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            above_cnt_q <= 8'h00;
        end else if (sel_valid) begin
            above_cnt_q <= (above && !above_hit) ? above_cnt_q + 8'h01 : 8'h00;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            below_cnt_q <= 8'h00;
        end else if (sel_valid) begin
            below_cnt_q <= (below && !below_hit) ? below_cnt_q + 8'h01 : 8'h00;
        end
    end

    always_comb begin
        flag_set = 4'h0;
        // [RULE3] Separate crossing flags
        flag_set[`STIR_FLAG_HIGH] = above_hit & ictl_q[`STIR_ICTL_LIM_EN];
        flag_set[`STIR_FLAG_LOW] = below_hit & ictl_q[`STIR_ICTL_LIM_EN];
        // [RULE22] Ready flags
        flag_set[`STIR_FLAG_PROX] = prox_in.valid & ictl_q[`STIR_ICTL_PROX_EN];
        flag_set[`STIR_FLAG_ALS] = als_in.valid & ictl_q[`STIR_ICTL_ALS_EN];
        flag_clr = (wr_reg && ptr_q == `STIR_OFF_FLAGS) ? bus.wr_data[3:0] : 4'h0;
        // [RULE4] Write one clears, set wins
        flags_d = (flags_q & ~flag_clr) | flag_set;
    end

    // [RULE2] Status flags
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            flags_q <= 4'h0;
        end else begin
            flags_q <= flags_d;
        end
    end

    // [RULE5] Pin low while any flag set
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            int_n_q <= 1'b1;
        end else begin
            int_n_q <= ~|flags_d;
        end
    end

    // [RULE11] Standby without demand
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            standby_q <= 1'b1;
        end else begin
            standby_q <= ~(prox_request_in | als_request_in);
        end
    end

    // [RULE12] Emitter sink forced off
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            led_sink_q <= 8'h00;
        end else begin
            led_sink_q <= (prox_request_in | als_request_in) ? led_current_in : 8'h00;
        end
    end

    assign standby_out = standby_q;
    assign led_sink_out = led_sink_q;
    assign int_n_out = int_n_q;
    // [RULE7] Delay field
    assign mod_delay_out = mtim_q[`STIR_MTIM_DLY_HI:`STIR_MTIM_DLY_LO];
    // [RULE23] Frequency field
    assign prox_freq_out = mtim_q[`STIR_MTIM_FRQ_HI:`STIR_MTIM_FRQ_LO];
    // [RULE8] Dead time field
    assign dead_time_out = mtim_q[`STIR_MTIM_DT_HI:`STIR_MTIM_DT_LO];

    default clocking @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    upper_byte_write_a: assert property ( // [RULE1]
        wr_reg && ptr_q == `STIR_OFF_HI_H |=> thr_hi_q[15:8] == $past(bus.wr_data))
        else $error("upper threshold high byte not written");

    lower_byte_write_a: assert property ( // [RULE17]
        wr_reg && ptr_q == `STIR_OFF_LO_L |=> thr_lo_q[7:0] == $past(bus.wr_data))
        else $error("lower threshold low byte not written");

    flag_sticky_a: assert property ( // [RULE4]
        flags_q[`STIR_FLAG_HIGH] && !(wr_reg && ptr_q == `STIR_OFF_FLAGS)
        |=> flags_q[`STIR_FLAG_HIGH]) else $error("high flag dropped without clear");

    int_pin_tracks_a: assert property ( // [RULE5]
        (|flags_q) == !int_n_out) else $error("interrupt pin disagrees with flags");

    timing_reset_a: assert property ( // [RULE7]
        $fell(reset_in) |-> mod_delay_out == 3'h0 && dead_time_out == 3'h1
        && prox_freq_out == 2'h0) else $error("timing register reset value wrong");

    prox_ready_set_a: assert property ( // [RULE22]
        prox_in.valid && ictl_q[`STIR_ICTL_PROX_EN] |=> flags_q[`STIR_FLAG_PROX] && !int_n_out)
        else $error("prox ready flag or pin missing");

    pointer_step_a: assert property ( // [RULE16]
        bus.rd_take |=> ptr_q == $past(ptr_q) + 8'h01) else $error("pointer did not step");

    standby_sink_a: assert property ( // [RULE12]
        !prox_request_in && !als_request_in |=> standby_out && led_sink_out == 8'h00)
        else $error("emitter sink active in standby");

    single_high_raise_a: assert property ( // [RULE21]
        prox_in.valid && !ictl_q[`STIR_ICTL_SEL] && ictl_q[7:5] == 3'h0
        && ictl_q[`STIR_ICTL_LIM_EN] && prox_in.value > thr_hi_q |=> flags_q[`STIR_FLAG_HIGH])
        else $error("high crossing not flagged");

    flag_clear_c: cover property (wr_reg && ptr_q == `STIR_OFF_FLAGS && |flags_q);
    repeat_read_c: cover property (bus.rd_take ##[1:1000] bus.rd_take);
    low_cross_c: cover property (flags_q[`STIR_FLAG_LOW] && ictl_q[`STIR_ICTL_SEL]);

endmodule
`default_nettype wire

//--- tb/stir_i2c_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "stir_cfg.svh"

module stir_i2c_host (
    // Clock
    input wire logic clk_in,
    // Bus wires
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // Phases of 8 clk, well above the 4 clk minimum
    task automatic bit_io(input logic b, output logic s);
        sda_low_out <= ~b;
        tick(8);
        scl_out <= 1'b1;
        tick(4);
        s = sda_in;
        tick(4);
        scl_out <= 1'b0;
        tick(1);
    endtask

    task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                           output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
            q[i] = s;
        end
        bit_io(ack_in, ack);
    endtask

    task automatic start_c();
        sda_low_out <= 1'b0;
        tick(8);
        scl_out <= 1'b1;
        tick(8);
        sda_low_out <= 1'b1;
        tick(8);
        scl_out <= 1'b0;
        tick(1);
    endtask

    task automatic stop_c();
        sda_low_out <= 1'b1;
        tick(8);
        scl_out <= 1'b1;
        tick(8);
        sda_low_out <= 1'b0;
        tick(8);
    endtask

    task automatic point(input logic [7:0] idx, output logic ack);
        logic [7:0] q;
        logic a;
        start_c();
        byte_io({`STIR_I2C_ADDR, 1'b0}, 1'b1, q, a);
        byte_io(idx, 1'b1, q, ack);
        ack = ack | a;
    endtask

    // Ack out is the sampled level: 0 means every byte was acked
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic ack);
        logic [7:0] q;
        logic a;
        point(idx, a);
        byte_io(d, 1'b1, q, ack);
        ack = ack | a;
        stop_c();
    endtask

    task automatic rd2(input logic [7:0] idx, input logic rs, output logic [15:0] d,
                       output logic ack);
        logic [7:0] q;
        logic a;
        logic b;
        point(idx, a);
        if (!rs) begin
            stop_c();
        end
        start_c();
        byte_io({`STIR_I2C_ADDR, 1'b1}, 1'b1, q, ack);
        byte_io(8'hff, 1'b0, d[15:8], b);
        byte_io(8'hff, 1'b1, d[7:0], b);
        stop_c();
        ack = ack | a;
    endtask
endmodule
`default_nettype wire

//--- tb/stir_top_test.sv
`timescale 1ns/1ps
`default_nettype none

module sensor_threshold_irq_regs_test;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic sda_wire;
    logic scl;
    logic host_low;
    logic sda_out;
    logic sda_oe_out;
    logic standby_out;
    logic int_n_out;
    logic prox_request_in = 1'b0;
    logic als_request_in = 1'b0;
    logic [7:0] led_current_in = 8'h00;
    logic [7:0] led_sink_out;
    logic [2:0] mod_delay_out;
    logic [2:0] dead_time_out;
    logic [1:0] prox_freq_out;
    stir_pkg::stir_result_s prox_in = '0;
    stir_pkg::stir_result_s als_in = '0;
    int n_mismatch = 0;
    int num_checks = 0;

    always #10 clk_in = ~clk_in;
    // Open drain: low if either side pulls
    assign sda_wire = ~(host_low | (sda_oe_out & ~sda_out));

    stir_top stir_top_inst (.clk_in(clk_in), .reset_in(reset_in), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .prox_in(prox_in),
        .als_in(als_in), .prox_request_in(prox_request_in), .als_request_in(als_request_in),
        .led_current_in(led_current_in), .led_sink_out(led_sink_out),
        .standby_out(standby_out), .mod_delay_out(mod_delay_out),
        .prox_freq_out(prox_freq_out), .dead_time_out(dead_time_out), .int_n_out(int_n_out));
    stir_i2c_host stir_i2c_host_inst (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl),
        .sda_low_out(host_low));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        logic ack;
        stir_i2c_host_inst.wr(idx, d, ack);
        check(16'(ack), 16'h0000);
    endtask

    task automatic rreg(input logic [7:0] idx, input logic rs, output logic [15:0] d);
        logic ack;
        stir_i2c_host_inst.rd2(idx, rs, d, ack);
        check(16'(ack), 16'h0000);
    endtask

    task automatic pulse(input logic src, input logic [15:0] v);
        if (src) begin
            als_in <= '{value: v, valid: 1'b1};
        end else begin
            prox_in <= '{value: v, valid: 1'b1};
        end
        @(posedge clk_in);
        als_in.valid <= 1'b0;
        prox_in.valid <= 1'b0;
        @(posedge clk_in);
    endtask

    // Flag byte expected after a crossing of the selected source
    function automatic logic [7:0] cross_flag(input logic sel);
        return sel ? 8'h02 : 8'h01;
    endfunction

    initial begin
        logic [15:0] d;
        logic [15:0] up;
        logic [15:0] lo;
        logic [15:0] v;
        logic [7:0] m;
        void'($urandom(49461));
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        check(16'(int_n_out), 16'h0001);
        check(16'(standby_out), 16'h0001);
        check(16'(led_sink_out), 16'h0000);
        check(16'({mod_delay_out, prox_freq_out, dead_time_out}), 16'h0001);
        rreg(8'h8e, 1'b1, d);
        check(d, 16'h0001);
        up = 16'($urandom_range(16'hefff, 16'h8000));
        lo = 16'($urandom_range(16'h7000, 16'h0100));
        wreg(8'h8a, lo[15:8]);
        wreg(8'h8b, lo[7:0]);
        wreg(8'h8c, up[15:8]);
        wreg(8'h8d, up[7:0]);
        rreg(8'h8a, 1'b1, d);
        check(d, lo);
        rreg(8'h8c, 1'b0, d);
        check(d, up);
        m = 8'($urandom);
        wreg(8'h8f, m);
        check(16'({mod_delay_out, prox_freq_out, dead_time_out}), 16'(m));
        // Two-byte read ends at 8Fh, never reaches 90h
        rreg(8'h8e, 1'b0, d);
        check(d, 16'(m));
        wreg(8'h8f, 8'h01);
        m = 8'($urandom);
        led_current_in <= m;
        prox_request_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        check(16'(standby_out), 16'h0000);
        check(16'(led_sink_out), 16'(m));
        prox_request_in <= 1'b0;
        als_request_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        check(16'(standby_out), 16'h0000);
        als_request_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        check(16'(led_sink_out), 16'h0000);
        wreg(8'h89, 8'h0c);
        pulse(1'b0, 16'($urandom));
        check(16'(int_n_out), 16'h0000);
        pulse(1'b1, 16'($urandom));
        rreg(8'h8e, 1'b1, d);
        check(d, 16'h0c01);
        wreg(8'h8e, 8'h00);
        rreg(8'h8e, 1'b0, d);
        check(d, 16'h0c01);
        wreg(8'h8e, 8'h08);
        rreg(8'h8e, 1'b1, d);
        check(d, 16'h0401);
        check(16'(int_n_out), 16'h0000);
        wreg(8'h8e, 8'h04);
        check(16'(int_n_out), 16'h0001);
        // Every count code, sources alternating
        for (int c = 0; c < 8; c++) begin
            wreg(8'h89, {c[2:0], 3'b000, 1'b1, c[0]});
            pulse(c[0], 16'h7800);
            v = c[0] ? lo - 16'($urandom_range(256, 1)) : up + 16'($urandom_range(256, 1));
            for (int k = 1; k < (1 << c); k++) begin
                pulse(c[0], v);
                pulse(~c[0], v);
            end
            rreg(8'h8e, 1'b1, d);
            check(d, 16'h0001);
            pulse(c[0], v);
            rreg(8'h8e, 1'b0, d);
            check(d, {cross_flag(c[0]), 8'h01});
            wreg(8'h8e, cross_flag(c[0]));
            check(16'(int_n_out), 16'h0001);
        end
        wreg(8'h89, 8'h00);
        pulse(1'b0, up + 16'h0001);
        rreg(8'h8e, 1'b1, d);
        check(d, 16'h0001);
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk_in);
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire
